// File: pkg/swl_pkg.sv
package swl_pkg;

   // opcodes, taken as one byte, most significant bit first
   localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
   localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
   localparam logic [7:0] OP_READ_CONFIG_ONE = 8'h35;
   localparam logic [7:0] OP_READ_CONFIG_TWO = 8'h3f;
   localparam logic [7:0] OP_READ_CONFIG_FOUR = 8'h45;
   localparam logic [7:0] OP_READ_CONFIG_FIVE = 8'h5e;
   localparam logic [7:0] OP_WRITE_ANY_REG = 8'h71;
   localparam logic [7:0] OP_READ_ANY_REG = 8'h65;
   // write class handled by the memory datapath, gated here by the latch
   localparam logic [7:0] OP_MEM_WRITE = 8'h02;
   localparam logic [7:0] OP_FAST_WRITE = 8'hda;
   localparam logic [7:0] OP_DUAL_INPUT_WRITE = 8'ha2;
   localparam logic [7:0] OP_DUAL_IO_WRITE = 8'ha1;
   localparam logic [7:0] OP_QUAD_INPUT_WRITE = 8'h32;
   localparam logic [7:0] OP_QUAD_IO_WRITE = 8'hd2;
   localparam logic [7:0] OP_DOUBLE_RATE_FAST_WRITE = 8'hdd;
   localparam logic [7:0] OP_DOUBLE_RATE_WRITE = 8'hde;
   localparam logic [7:0] OP_DOUBLE_RATE_QUAD_IO_WRITE = 8'hd1;
   localparam logic [7:0] OP_SPECIAL_SECTOR_WRITE = 8'h42;
   localparam logic [7:0] OP_SERIAL_NUMBER_WRITE = 8'hc2;

   // register slots, index equals the low address byte
   localparam int REG_CNT = 7;
   localparam int IDX_ST1 = 0;
   localparam int IDX_SR2 = 1;
   localparam int IDX_CR1 = 2;
   localparam int IDX_CR2 = 3;
   localparam int IDX_CR4 = 5;
   localparam int IDX_CF5 = 6;
   localparam logic [REG_CNT-1:0] ANY_WRITABLE = 7'h6d;
   localparam logic [15:0] ADDR_VOL_PAGE = 16'h0700;
   localparam logic [15:0] ADDR_NV_PAGE = 16'h0000;

   // field positions
   localparam int ST1_BUSY_BIT = 0;
   localparam int ST1_LATCH_BIT = 1;
   localparam int ST1_WDIS_BIT = 7;
   localparam int CF5_LAT_LO_BIT = 0;
   localparam int CF5_LAT_HI_BIT = 1;

   // reset values and the bits that a nonvolatile copy backs
   localparam logic [7:0] ST1_RST = 8'h00;
   localparam logic [7:0] SR2_RST = 8'h00;
   localparam logic [7:0] CR1_RST = 8'h00;
   localparam logic [7:0] CR2_RST = 8'h00;
   localparam logic [7:0] CR4_RST = 8'h00;
   localparam logic [7:0] CF5_RST = 8'h00;
   localparam logic [7:0] UNUSED_RST = 8'h00;
   localparam logic [7:0] VOL_RST [REG_CNT] = '{ST1_RST, SR2_RST, CR1_RST,
      CR2_RST, UNUSED_RST, CR4_RST, CF5_RST};
   localparam logic [7:0] ST1_NV_MASK = 8'hfc;
   localparam logic [7:0] FULL_NV_MASK = 8'hff;
   localparam logic [7:0] NO_NV_MASK = 8'h00;
   localparam logic [7:0] NV_MASK [REG_CNT] = '{ST1_NV_MASK, NO_NV_MASK,
      FULL_NV_MASK, FULL_NV_MASK, NO_NV_MASK, FULL_NV_MASK, FULL_NV_MASK};

   // frame positions, counted in rising link clock edges
   localparam logic [5:0] POS_OPCODE = 6'd8;
   localparam logic [5:0] POS_STWR_END = 6'd16;
   localparam logic [5:0] POS_ADDR_END = 6'd32;
   localparam logic [5:0] POS_ANYWR_END = 6'd40;
   localparam logic [5:0] POS_MAX = 6'd63;
   localparam logic [5:0] READ_BITS = 6'd8;

   typedef enum {
      CMD_NONE,
      CMD_SET_LATCH,
      CMD_CLR_LATCH,
      CMD_WRITE_STATUS,
      CMD_WRITE_ANY,
      CMD_READ_FIXED,
      CMD_READ_ANY,
      CMD_OTHER_WRITE
   } swl_cmd_e;

   function automatic swl_cmd_e swl_decode(input logic [7:0] op);
      case (op)
         OP_SET_WRITE_LATCH: return CMD_SET_LATCH;
         OP_CLEAR_WRITE_LATCH: return CMD_CLR_LATCH;
         OP_WRITE_STATUS: return CMD_WRITE_STATUS;
         OP_WRITE_ANY_REG: return CMD_WRITE_ANY;
         OP_READ_ANY_REG: return CMD_READ_ANY;
         OP_READ_STATUS_ONE, OP_READ_STATUS_TWO, OP_READ_CONFIG_ONE,
         OP_READ_CONFIG_TWO, OP_READ_CONFIG_FOUR,
         OP_READ_CONFIG_FIVE: return CMD_READ_FIXED;
         OP_MEM_WRITE, OP_FAST_WRITE, OP_DUAL_INPUT_WRITE, OP_DUAL_IO_WRITE,
         OP_QUAD_INPUT_WRITE, OP_QUAD_IO_WRITE, OP_DOUBLE_RATE_FAST_WRITE,
         OP_DOUBLE_RATE_WRITE, OP_DOUBLE_RATE_QUAD_IO_WRITE,
         OP_SPECIAL_SECTOR_WRITE,
         OP_SERIAL_NUMBER_WRITE: return CMD_OTHER_WRITE;
         default: return CMD_NONE;
      endcase
   endfunction

   function automatic int swl_read_index(input logic [7:0] op);
      case (op)
         OP_READ_STATUS_TWO: return IDX_SR2;
         OP_READ_CONFIG_ONE: return IDX_CR1;
         OP_READ_CONFIG_TWO: return IDX_CR2;
         OP_READ_CONFIG_FOUR: return IDX_CR4;
         OP_READ_CONFIG_FIVE: return IDX_CF5;
         default: return IDX_ST1;
      endcase
   endfunction

endpackage

// File: hdl/swl_sync.sv
`timescale 1ns/1ps
module swl_sync #(
   parameter int WIDTH = 1
) (
   input logic clk_i,
   input logic rst_n_i,
   input logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   always_comb begin
      meta_nxt = d_i;
      q_nxt = meta_r;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;
endmodule

// File: hdl/swl_core.sv
`timescale 1ns/1ps
module swl_core import swl_pkg::*; (
   input logic clk_sys_i,
   input logic rst_n_i,
   input logic por_n_i,
   input logic soft_rst_i,
   input logic sck_link_i,
   input logic cs_n_i,
   input logic si_i,
   output logic so_o,
   output logic so_oe_o,
   input logic wp_n_i,
   input logic wip_i,
   input logic [7:0] status_two_i,
   output logic write_enable_latch_o,
   output logic write_rejected_o,
   output logic [7:0] status_reg_one_o,
   output logic [7:0] config_reg_five_o
);
   // ---------------- link domain: capture ----------------
   // cs_n high clears the frame state at once, as the link clock may stop
   logic frame_rst_n;
   logic in_frame_r;
   logic frame_tog_r;
   logic frame_tog_nxt;
   logic [5:0] pos_base;
   logic [5:0] pos_r;
   logic [5:0] pos_nxt;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [7:0] opcode_r;
   logic [7:0] opcode_nxt;
   logic [23:0] addr_r;
   logic [23:0] addr_nxt;
   logic [7:0] data_r;
   logic [7:0] data_nxt;

   assign frame_rst_n = rst_n_i & ~cs_n_i;

   always_comb begin
      pos_base = in_frame_r ? pos_r : 6'd0;
      pos_nxt = (pos_base == POS_MAX) ? pos_base : pos_base + 6'd1;
      frame_tog_nxt = in_frame_r ? frame_tog_r : ~frame_tog_r;
      shift_nxt = {shift_r[6:0], si_i};
      opcode_nxt = (pos_nxt == POS_OPCODE) ? shift_nxt : opcode_r;
      addr_nxt = addr_r;
      if (pos_nxt > POS_OPCODE && pos_nxt <= POS_ADDR_END &&
          pos_nxt[2:0] == 3'd0) begin
         addr_nxt = {addr_r[15:0], shift_nxt};
      end
      data_nxt = data_r;
      if ((opcode_r == OP_WRITE_STATUS && pos_nxt == POS_STWR_END) ||
          (opcode_r == OP_WRITE_ANY_REG && pos_nxt == POS_ANYWR_END)) begin
         data_nxt = shift_nxt;
      end
   end

   always_ff @(posedge sck_link_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         in_frame_r <= 1'b0;
      end else begin
         in_frame_r <= 1'b1;
      end
   end

   // capture words persist past the frame so the system side can act on them
   always_ff @(posedge sck_link_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_tog_r <= 1'b0;
         pos_r <= 6'd0;
         shift_r <= 8'h00;
         opcode_r <= 8'h00;
         addr_r <= 24'h000000;
         data_r <= 8'h00;
      end else begin
         frame_tog_r <= frame_tog_nxt;
         pos_r <= pos_nxt;
         shift_r <= shift_nxt;
         opcode_r <= opcode_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
      end
   end

   // ---------------- link domain: read data out ----------------
   logic [7:0] snap_vol_r [REG_CNT];
   logic [7:0] snap_vol_nxt [REG_CNT];
   logic [7:0] snap_nv_r [REG_CNT];
   logic [7:0] snap_nv_nxt [REG_CNT];
   swl_cmd_e link_cmd;
   logic rd_cmd;
   logic [5:0] dummy;
   logic [5:0] rd_start;
   logic [7:0] rd_byte;
   logic [7:0] out_r;
   logic [7:0] out_nxt;
   logic so_r;
   logic so_nxt;
   logic oe_r;
   logic oe_nxt;

   always_comb begin
      link_cmd = swl_decode(opcode_r);
      rd_cmd = (link_cmd == CMD_READ_FIXED || link_cmd == CMD_READ_ANY) &&
               pos_r >= POS_OPCODE;
      dummy = {4'd0, snap_vol_r[IDX_CF5][CF5_LAT_HI_BIT],
               snap_vol_r[IDX_CF5][CF5_LAT_LO_BIT]};
      rd_start = ((link_cmd == CMD_READ_ANY) ? POS_ADDR_END : POS_OPCODE) +
                 dummy;
      rd_byte = 8'h00;
      if (link_cmd == CMD_READ_FIXED) begin
         rd_byte = snap_vol_r[swl_read_index(opcode_r)];
      end else if (addr_r[7:0] < 8'(REG_CNT)) begin
         if (addr_r[23:8] == ADDR_VOL_PAGE ||
             (addr_r[23:8] == ADDR_NV_PAGE && addr_r[7:0] == 8'(IDX_SR2))) begin
            rd_byte = snap_vol_r[addr_r[2:0]];
         end else if (addr_r[23:8] == ADDR_NV_PAGE) begin
            rd_byte = snap_nv_r[addr_r[2:0]];
         end
      end
      out_nxt = out_r;
      so_nxt = so_r;
      oe_nxt = oe_r;
      if (rd_cmd && pos_r == rd_start) begin
         so_nxt = rd_byte[7];
         out_nxt = {rd_byte[6:0], 1'b0};
         oe_nxt = 1'b1;
      end else if (oe_r) begin
         if (pos_r == rd_start + READ_BITS) begin
            oe_nxt = 1'b0;
         end else begin
            so_nxt = out_r[7];
            out_nxt = {out_r[6:0], 1'b0};
         end
      end
   end

   // mode 0 only: data changes on the falling edge, sampled on the rising
   always_ff @(negedge sck_link_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         out_r <= 8'h00;
         so_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         so_r <= so_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign so_o = so_r;
   assign so_oe_o = oe_r;

   // ---------------- system domain ----------------
   logic cs_q;
   logic wp_n_q;
   logic tog_q;
   logic cs_d_r;
   logic seen_r;
   logic seen_nxt;
   logic frame_ev;
   logic reload_r;
   logic reload_nxt;
   logic rejected_r;
   logic rejected_nxt;
   logic protect;
   logic latch_set;
   logic wr_ok;
   logic [7:0] vol_r [REG_CNT];
   logic [7:0] vol_nxt [REG_CNT];
   logic [7:0] nv_r [REG_CNT];
   logic [7:0] nv_nxt [REG_CNT];
   swl_cmd_e sys_cmd;
   int widx;

   swl_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .d_i({cs_n_i, wp_n_i, frame_tog_r}),
      .q_o({cs_q, wp_n_q, tog_q})
   );

   // a select pulse with no clock edge does not toggle, so stale capture
   // words from the previous frame are never replayed
   assign frame_ev = cs_q & ~cs_d_r & (tog_q != seen_r);

   always_comb begin
      vol_nxt = vol_r;
      nv_nxt = nv_r;
      reload_nxt = 1'b0;
      rejected_nxt = 1'b0;
      seen_nxt = frame_ev ? tog_q : seen_r;
      sys_cmd = swl_decode(opcode_r);
      widx = int'(addr_r[2:0]);
      protect = vol_r[IDX_ST1][ST1_WDIS_BIT] & ~wp_n_q;
      latch_set = vol_r[IDX_ST1][ST1_LATCH_BIT];
      wr_ok = latch_set & ~protect;
      // word crossing: held stable while the frame runs
      snap_vol_nxt = cs_q ? vol_r : snap_vol_r;
      snap_nv_nxt = cs_q ? nv_r : snap_nv_r;
      vol_nxt[IDX_SR2] = status_two_i;
      if (reload_r) begin
         for (int i = 0; i < REG_CNT; i++) begin
            vol_nxt[i] = (VOL_RST[i] & ~NV_MASK[i]) | (nv_r[i] & NV_MASK[i]);
         end
         vol_nxt[IDX_SR2] = status_two_i;
      end else if (frame_ev && pos_r >= POS_OPCODE) begin
         case (sys_cmd)
            CMD_SET_LATCH: begin
               if (pos_r == POS_OPCODE) begin
                  vol_nxt[IDX_ST1][ST1_LATCH_BIT] = 1'b1;
               end
            end
            CMD_CLR_LATCH: begin
               if (pos_r == POS_OPCODE && !wip_i) begin
                  vol_nxt[IDX_ST1][ST1_LATCH_BIT] = 1'b0;
               end
            end
            CMD_WRITE_STATUS: begin
               if (pos_r == POS_STWR_END && wr_ok) begin
                  nv_nxt[IDX_ST1] = (nv_r[IDX_ST1] & ~ST1_NV_MASK) |
                                    (data_r & ST1_NV_MASK);
                  vol_nxt[IDX_ST1] = (vol_r[IDX_ST1] & ~ST1_NV_MASK) |
                                     (data_r & ST1_NV_MASK);
               end
               vol_nxt[IDX_ST1][ST1_LATCH_BIT] = 1'b0;
            end
            CMD_WRITE_ANY: begin
               if (pos_r == POS_ANYWR_END && wr_ok &&
                   addr_r[7:0] < 8'(REG_CNT) && ANY_WRITABLE[widx] &&
                   (addr_r[23:8] == ADDR_VOL_PAGE ||
                    addr_r[23:8] == ADDR_NV_PAGE)) begin
                  vol_nxt[widx] = (vol_r[widx] & ~NV_MASK[widx]) |
                                  (data_r & NV_MASK[widx]);
                  if (addr_r[23:8] == ADDR_NV_PAGE) begin
                     nv_nxt[widx] = data_r;
                  end
               end
               vol_nxt[IDX_ST1][ST1_LATCH_BIT] = 1'b0;
            end
            CMD_OTHER_WRITE: begin
               rejected_nxt = ~latch_set;
            end
            default: begin
            end
         endcase
      end
      // write in progress is shown live, never stored
      vol_nxt[IDX_ST1][ST1_BUSY_BIT] = wip_i;
      if (soft_rst_i) begin
         vol_nxt = VOL_RST;
         reload_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_d_r <= 1'b0;
         seen_r <= 1'b0;
         reload_r <= 1'b1;
         rejected_r <= 1'b0;
         vol_r <= VOL_RST;
         snap_vol_r <= VOL_RST;
         snap_nv_r <= VOL_RST;
      end else begin
         cs_d_r <= cs_q;
         seen_r <= seen_nxt;
         reload_r <= reload_nxt;
         rejected_r <= rejected_nxt;
         vol_r <= vol_nxt;
         snap_vol_r <= snap_vol_nxt;
         snap_nv_r <= snap_nv_nxt;
      end
   end

   // nonvolatile copies survive every reset except power-on
   always_ff @(posedge clk_sys_i or negedge por_n_i) begin
      if (!por_n_i) begin
         nv_r <= VOL_RST;
      end else begin
         nv_r <= nv_nxt;
      end
   end

   assign write_enable_latch_o = vol_r[IDX_ST1][ST1_LATCH_BIT];
   assign write_rejected_o = rejected_r;
   assign status_reg_one_o = vol_r[IDX_ST1];
   assign config_reg_five_o = vol_r[IDX_CF5];

   // ---------------- checks ----------------
   sequence s_done(logic [7:0] op, logic [5:0] len);
      frame_ev && !reload_r && !soft_rst_i && opcode_r == op && pos_r == len;
   endsequence

   sequence s_stwr_try;
      frame_ev && !reload_r && !soft_rst_i && opcode_r == OP_WRITE_STATUS &&
      pos_r == POS_STWR_END;
   endsequence

   a_set_latch_done: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_done(OP_SET_WRITE_LATCH, POS_OPCODE) |=> write_enable_latch_o)
      else $error("latch not set after set opcode");

   a_clear_latch_done: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_done(OP_CLEAR_WRITE_LATCH, POS_OPCODE) ##0 !wip_i
      |=> !write_enable_latch_o)
      else $error("latch not cleared after clear opcode");

   a_clear_when_busy: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_done(OP_CLEAR_WRITE_LATCH, POS_OPCODE) ##0 wip_i
      |=> $stable(write_enable_latch_o))
      else $error("latch changed while busy");

   a_latch_only_at_end: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $changed(write_enable_latch_o) |-> $past(frame_ev) || $past(reload_r) ||
      $past(soft_rst_i))
      else $error("latch moved outside a frame end");

   a_partial_discard: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      frame_ev && !reload_r && !soft_rst_i && pos_r < POS_OPCODE
      |=> $stable(status_reg_one_o[7:1]) && $stable(config_reg_five_o))
      else $error("partial opcode changed a register");

   a_stwr_needs_latch: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_stwr_try ##0 !write_enable_latch_o |=> $stable(status_reg_one_o[7:2]))
      else $error("status write without latch took effect");

   a_stwr_protected: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_stwr_try ##0 status_reg_one_o[ST1_WDIS_BIT] && !wp_n_q
      |=> $stable(status_reg_one_o[7:2]))
      else $error("protected status write took effect");

   a_stwr_stores_nv: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i || !por_n_i)
      s_stwr_try ##0 wr_ok |=> nv_r[IDX_ST1][7:2] == $past(data_r[7:2])
      && status_reg_one_o[7:2] == $past(data_r[7:2]))
      else $error("status write not stored");

   a_stwr_drops_latch: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_stwr_try |=> !write_enable_latch_o ##1 !write_enable_latch_o
      || $past(frame_ev))
      else $error("latch kept after status write");

   a_anywr_protected: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_done(OP_WRITE_ANY_REG, POS_ANYWR_END) ##0 protect
      |=> $stable(config_reg_five_o) && $stable(status_reg_one_o[7:2]))
      else $error("protected write-any took effect");

   a_reload_values: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i || !por_n_i)
      reload_r && !soft_rst_i |=> config_reg_five_o == $past(nv_r[IDX_CF5])
      && !write_enable_latch_o)
      else $error("reset reload wrong");

   a_other_write_gate: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      frame_ev && !reload_r && pos_r >= POS_OPCODE &&
      sys_cmd == CMD_OTHER_WRITE && !write_enable_latch_o
      |=> write_rejected_o ##1 !write_rejected_o)
      else $error("write without latch not rejected");

   a_wip_reported: assert property (
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      $changed(wip_i) |=> status_reg_one_o[ST1_BUSY_BIT] == $past(wip_i))
      else $error("write in progress not shown");

   a_read_byte_len: assert property (
      @(negedge sck_link_i) disable iff (!frame_rst_n)
      rd_cmd && pos_r == rd_start |=> so_oe_o [*8] ##1 !so_oe_o)
      else $error("read byte window wrong");

   a_unknown_quiet: assert property (
      @(negedge sck_link_i) disable iff (!frame_rst_n)
      pos_r >= POS_OPCODE && link_cmd == CMD_NONE |=> !so_oe_o)
      else $error("unknown opcode drove data");
endmodule

// File: dv/swl_host.sv
`timescale 1ns/1ps
module swl_host (
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o,
   input wire logic so_i
);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
   end
   // sends the low n bits of val msb first, collects so on edges s+1..s+8
   task automatic frame(input logic [63:0] val, input int n, input int s,
      output logic [7:0] rd);
      rd = 8'h00;
      cs_n_o = 1'b0;
      for (int k = n; k >= 1; k--) begin
         si_o = val[k-1];
         #24;
         sck_o = 1'b1;
         if (n - k + 1 > s && n - k + 1 <= s + 8) begin
            rd = {rd[6:0], so_i};
         end
         #24;
         sck_o = 1'b0;
      end
      #24;
      cs_n_o = 1'b1;
      si_o = ~si_o;
      // select stays high well past the sync delay before the next frame
      #100;
   endtask
endmodule

// File: dv/swl_core_test.sv
`timescale 1ns/1ps
module swl_core_test import swl_pkg::*; ;
   logic clk_sys_i = 1'b0;
   logic rst_n_i, por_n_i, soft_rst_i, wp_n_i, wip_i;
   logic [7:0] status_two_i, st_one, cfg_five, rej_cnt, oe_cnt;
   logic cs_n, sck, si, so, so_oe, wlatch, rej;
   int errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   swl_core DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
      .soft_rst_i(soft_rst_i), .sck_link_i(sck), .cs_n_i(cs_n), .si_i(si),
      .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n_i), .wip_i(wip_i),
      .status_two_i(status_two_i), .write_enable_latch_o(wlatch),
      .write_rejected_o(rej), .status_reg_one_o(st_one),
      .config_reg_five_o(cfg_five));
   swl_host u_host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so));
   initial begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (rej === 1'b1) rej_cnt++;
      if (so_oe === 1'b1) oe_cnt++;
      if (cyc == 30000) begin
         errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [63:0] val, input int n);
      logic [7:0] rd;
      u_host.frame(val, n, 99, rd);
   endtask
   task automatic latch_on();
      send(64'(OP_SET_WRITE_LATCH), 8);
   endtask
   task automatic t_latch();
      chk(st_one, 8'h00);
      send(64'h03, 7);
      chk({7'h0, wlatch}, 8'h00);
      send({OP_SET_WRITE_LATCH, 1'b0}, 9);
      chk({7'h0, wlatch}, 8'h00);
      latch_on();
      chk(st_one, 8'h02);
      @(negedge clk_sys_i) wip_i <= 1'b1;
      send(64'(OP_CLEAR_WRITE_LATCH), 8);
      chk(st_one, 8'h03);
      @(negedge clk_sys_i) wip_i <= 1'b0;
      send(64'(OP_CLEAR_WRITE_LATCH), 8);
      chk({7'h0, wlatch}, 8'h00);
      $display("latch test done");
   endtask
   task automatic t_write_status_cmd();
      send({OP_WRITE_STATUS, 8'hfc}, 16);
      chk(st_one, 8'h00);
      latch_on();
      send({OP_WRITE_STATUS, 8'ha8}, 16);
      chk(st_one, 8'ha8);
      @(negedge clk_sys_i) soft_rst_i <= 1'b1;
      @(negedge clk_sys_i) soft_rst_i <= 1'b0;
      repeat (4) @(negedge clk_sys_i);
      chk(st_one, 8'ha8);
      wp_n_i <= 1'b0;
      latch_on();
      send({OP_WRITE_STATUS, 8'h00}, 16);
      chk(st_one, 8'ha8);
      latch_on();
      send({OP_WRITE_ANY_REG, 24'h000000, 8'h00}, 40);
      chk(st_one, 8'ha8);
      @(negedge clk_sys_i) wp_n_i <= 1'b1;
      latch_on();
      send({OP_WRITE_STATUS, 8'h00}, 16);
      chk(st_one, 8'h00);
      $display("status write test done");
   endtask
   task automatic t_reads();
      logic [7:0] ops [6] = '{OP_READ_STATUS_ONE, OP_READ_STATUS_TWO,
         OP_READ_CONFIG_ONE, OP_READ_CONFIG_TWO, OP_READ_CONFIG_FOUR,
         OP_READ_CONFIG_FIVE};
      logic [7:0] exps [6] = '{8'h02, 8'h5a, 8'h00, 8'h00, 8'h00, 8'h02};
      logic [7:0] rd;
      latch_on();
      send({OP_WRITE_ANY_REG, 24'h070006, 8'h02}, 40);
      chk(cfg_five, 8'h02);
      latch_on();
      oe_cnt = 8'h00;
      // latency code 2 puts two dummy edges after the opcode
      for (int i = 0; i < 6; i++) begin
         u_host.frame(64'(ops[i]) << 10, 18, 10, rd);
         chk(rd, exps[i]);
      end
      chk(8'(oe_cnt != 0), 8'h01);
      u_host.frame({OP_READ_ANY_REG, 24'h070006} << 10, 42, 34, rd);
      chk(rd, 8'h02);
      $display("read test done");
   endtask
   task automatic t_reject();
      logic [7:0] wops [3] = '{OP_MEM_WRITE, OP_SPECIAL_SECTOR_WRITE,
         OP_SERIAL_NUMBER_WRITE};
      send(64'(OP_CLEAR_WRITE_LATCH), 8);
      rej_cnt = 8'h00;
      for (int i = 0; i < 3; i++) begin
         send({wops[i], 32'h0}, 40);
      end
      chk(rej_cnt, 8'h03);
      latch_on();
      send({OP_MEM_WRITE, 32'h0}, 40);
      chk(rej_cnt, 8'h03);
      oe_cnt = 8'h00;
      send({8'hff, 8'h00}, 16);
      chk(oe_cnt, 8'h00);
      $display("reject test done");
   endtask
   initial begin
      rst_n_i = 1'b0;
      por_n_i = 1'b0;
      soft_rst_i = 1'b0;
      wp_n_i = 1'b1;
      wip_i = 1'b0;
      status_two_i = 8'h5a;
      rej_cnt = 8'h00;
      oe_cnt = 8'h00;
      repeat (12) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      por_n_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      t_latch();
      t_write_status_cmd();
      t_reads();
      t_reject();
      test_done();
   end
endmodule
